/* File: testbench.sv */
`timescale 1ns/1ps
module testbench;
   import usb_ep_ctrl_pkg::*;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [31:0] avs_readdata;
   logic avs_waitrequest, usb_reset_in = 1'b0;
   logic tok_valid, data_done, data_ok, data_pid1, host_ack, xfer_abort;
   logic hs_valid, tx_start, tx_data1, rx_arm, iface_in_reset;
   logic [1:0] tok_pid_bits, hs_code;
   logic [6:0] tok_addr, dev;
   logic [3:0] tok_ep, data_len, tx_len, len;
   logic [15:0] buf_addr;
   logic [7:0] base; // Random buffer base.
   logic [35:0] exp_q[$]; // Kind nibble above the expected value.
   int errors = 0;
   int n_compared = 0;
   initial forever #50 sys_clk = ~sys_clk;
   usb_ep_ctrl u_dut (.sys_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .usb_reset_in, .tok_valid,
      .tok_pid_bits, .tok_addr, .tok_ep, .data_done, .data_ok, .data_pid1, .data_len,
      .host_ack, .xfer_abort, .hs_valid, .hs_code, .tx_start, .tx_data1, .tx_len, .rx_arm,
      .buf_addr, .iface_in_reset);
   usb_host_model u_host (.sys_clk, .tx_start, .tok_valid, .tok_pid_bits, .tok_addr, .tok_ep,
      .data_done, .data_ok, .data_pid1, .data_len, .host_ack, .xfer_abort);
   task automatic check(input logic [35:0] seen, input logic [35:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      if (errors == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Any result with no note waiting is compared against zero and so fails.
   task automatic take(input logic [35:0] seen);
      check(seen, (exp_q.size() > 0) ? exp_q.pop_front() : 36'h0);
   endtask
   always @(posedge sys_clk) begin
      if (!rst && hs_valid === 1'b1) take({4'h1, 30'h0, hs_code});
      if (!rst && tx_start === 1'b1) take({4'h2, 11'h0, tx_data1, tx_len, buf_addr});
      if (!rst && rx_arm === 1'b1) take({4'h3, 16'h0000, buf_addr});
      if (avs_read && avs_waitrequest === 1'b0) take({4'h4, avs_readdata});
   end
   function automatic void ex(input logic [3:0] k, input logic [31:0] v);
      exp_q.push_back({k, v});
   endfunction
   // One Avalon transfer, held until waitrequest is seen low.
   task automatic bus(input logic [3:0] a, input logic w, input logic [7:0] d);
      int n;
      avs_address <= a;
      avs_write <= w;
      avs_read <= !w;
      avs_writedata <= {24'h00_0000, d};
      for (n = 0; n < 20; n++) begin
         @(posedge sys_clk);
         if (avs_waitrequest === 1'b0) break;
      end
      if (n == 20) begin
         errors++;
         complete_run();
      end
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      ex(4'h4, {24'h00_0000, e});
      bus(a, 1'b0, 8'h00);
   endtask
   // Waits, bounded, until every noted result has shown up.
   task automatic drain();
      int n;
      for (n = 0; n < 40 && exp_q.size() > 0; n++) @(posedge sys_clk);
      if (exp_q.size() > 0) begin
         errors++;
         complete_run();
      end
      repeat (8) @(posedge sys_clk);
   endtask
   task automatic xfer(input logic [1:0] p, input logic [3:0] e, input logic [3:0] n);
      u_host.token(p, dev, e);
      repeat (3) @(posedge sys_clk);
      u_host.data(1'b0, n);
      drain();
   endtask
   initial begin
      repeat (20000) @(posedge sys_clk);
      errors++;
      complete_run();
   end
   initial begin
      void'($urandom(32'hcb98));
      dev = 7'($urandom_range(1, 127));
      base = 8'($urandom);
      len = 4'($urandom_range(0, 8)); // Length 0 to 8.
      repeat (8) @(posedge sys_clk);
      rst <= 1'b0;
      rd(4'h7, 8'h80);
      rd(4'hc, 8'h00);
      bus(4'h0, 1'b1, {1'b1, dev});
      rd(4'h0, {1'b0, dev});
      bus(4'h1, 1'b1, base);
      bus(4'h7, 1'b1, 8'h3f); // Endpoint 0 receive enabled soon after reset.
      rd(4'h7, 8'hb0);
      u_host.token(TOK_OUT, dev ^ 7'h01, 4'h0); // A foreign address gets nothing.
      drain();
      ex(4'h3, {16'h0000, base, 8'h00});
      ex(4'h1, 32'(HS_ACK));
      xfer(TOK_OUT, 4'h0, 4'h3);
      rd(4'h7, 8'he0);
      rd(4'h4, 8'h20);
      rd(4'h2, 8'h03);
      bus(4'h6, 1'b1, {4'h3, len}); // Transmit armed while the flag is pending, so NAK first.
      ex(4'h1, 32'(HS_NAK));
      u_host.token(TOK_IN, dev, 4'h0);
      drain();
      bus(4'h4, 1'b1, 8'h20);
      u_host.ack_dly = 4; // A slow host this time.
      ex(4'h2, {11'h0, 1'b0, len, base, 8'h08});
      u_host.token(TOK_IN, dev, 4'h0);
      drain();
      rd(4'h6, {4'h6, len});
      rd(4'h3, 8'h80);
      bus(4'h4, 1'b1, 8'h20);
      // Disabled, stall and NAK in both directions.
      for (int s = 0; s < 3; s++) begin
         bus(4'h6, 1'b1, 8'(s << 4));
         bus(4'h7, 1'b1, 8'(s << 4));
         if (s != 0) ex(4'h1, (s == 1) ? 32'(HS_STALL) : 32'(HS_NAK));
         u_host.token(TOK_IN, dev, 4'h0);
         drain();
         if (s != 0) ex(4'h1, (s == 1) ? 32'(HS_STALL) : 32'(HS_NAK));
         xfer(TOK_OUT, 4'h0, 4'h1);
      end
      bus(4'h6, 1'b1, 8'h80);
      bus(4'h7, 1'b1, 8'h30);
      ex(4'h3, {16'h0000, base, 8'h00});
      ex(4'h1, 32'(HS_STALL));
      xfer(TOK_OUT, 4'h0, 4'h2);
      bus(4'h6, 1'b1, 8'h30);
      bus(4'h7, 1'b1, 8'h70);
      ex(4'h3, {16'h0000, base, 8'h00});
      ex(4'h1, 32'(HS_ACK));
      xfer(TOK_SETUP, 4'h0, 4'h8);
      rd(4'h6, 8'h60);
      rd(4'h7, 8'he0);
      rd(4'h3, 8'hc0);
      bus(4'h4, 1'b1, 8'h20);
      bus(4'h9, 1'b1, 8'h31);
      ex(4'h3, {16'h0000, base, 8'h10});
      ex(4'h1, 32'(HS_ACK));
      xfer(TOK_OUT, 4'h1, 4'h8);
      bus(4'h4, 1'b1, 8'h20);
      usb_reset_in <= 1'b1;
      repeat (4) @(posedge sys_clk);
      usb_reset_in <= 1'b0;
      @(posedge sys_clk);
      u_host.token(TOK_IN, 7'h00, 4'h0); // Endpoints disabled, so no answer.
      drain();
      rd(4'h0, 8'h00);
      rd(4'h9, 8'h00);
      rd(4'h4, 8'h02);
      bus(4'h4, 1'b1, 8'h02);
      bus(4'h5, 1'b1, 8'h01);
      bus(4'h0, 1'b1, {1'b0, dev});
      rd(4'h0, 8'h00);
      bus(4'h5, 1'b1, 8'h00);
      rd(4'h4, 8'h02);
      complete_run();
   end
endmodule

/* File: usb_ep_ctrl.sv */
`timescale 1ns/1ps
`include "usb_ep_ctrl_regs.svh"
// What this block does
// - Hold 7-bit device address, top bit zero.
// - Clear device address on bus or forced reset.
// - Status-expect flag stalls nonzero-length OUT data.
// - Transmit toggle: set on SETUP, flips on ACK.
// - Transmit status: disabled, stall, NAK, valid.
// - Correct IN or SETUP forces transmit NAK.
// - Control flag makes endpoint 1 or 2 control.
// - Receive toggle set to one at setup stage.
// - Receive toggle flips only on matching data.
// - Receive status: disabled, stall, NAK, valid.
// - Correct OUT or SETUP forces receive NAK.
// - Endpoints 1, 2 match software endpoint number.
// - Endpoint 0 receive: bit7 one, low zero.
// - Bus reset disables every endpoint.
// - Buffer base from upper ten address bits.
// - Buffers fill upward from three zero bits.
// - Pending correct-transfer NAKs IN and OUT on all valid endpoints.
// - SETUP correct transfer NAKs both directions.
// - Captured token and endpoint frozen while pending.
// - Only error-free, expected-toggle transfers count correct.
// - Forced reset holds; release flags bus reset.
module usb_ep_ctrl
   import usb_ep_ctrl_pkg::*;
(
   input wire logic sys_clk, // System clock, 10 MHz.
   input wire logic rst, // Synchronous reset, active high.
   input wire logic [3:0] avs_address, // Avalon word address.
   input wire logic avs_read, // Avalon read request.
   input wire logic avs_write, // Avalon write request.
   input wire logic [31:0] avs_writedata, // Avalon write data, low byte used.
   input wire logic [3:0] avs_byteenable, // Avalon byte enables, lane 0 gates writes.
   output logic [31:0] avs_readdata, // Avalon read data.
   output logic avs_waitrequest, // Avalon wait request.
   input wire logic usb_reset_in, // Bus reset seen by the line receiver.
   input wire logic tok_valid, // Token received, one-cycle pulse.
   input wire logic [1:0] tok_pid_bits, // Variable token PID bits.
   input wire logic [6:0] tok_addr, // Token address field.
   input wire logic [3:0] tok_ep, // Token endpoint field.
   input wire logic data_done, // Data packet ended, one-cycle pulse.
   input wire logic data_ok, // Data packet free of PID, CRC, stuff errors.
   input wire logic data_pid1, // Data packet was DATA1.
   input wire logic [3:0] data_len, // Data packet byte count.
   input wire logic host_ack, // Host ACK after our IN data, pulse.
   input wire logic xfer_abort, // Transaction timed out, pulse.
   output logic hs_valid, // Send handshake, one-cycle pulse.
   output logic [1:0] hs_code, // Handshake kind.
   output logic tx_start, // Send IN data packet, one-cycle pulse.
   output logic tx_data1, // Data packet PID is DATA1.
   output logic [3:0] tx_len, // Bytes to send.
   output logic rx_arm, // Store incoming data in buffer, pulse.
   output logic [15:0] buf_addr, // Buffer start address for the transfer.
   output logic iface_in_reset // Interface held in reset.
);
   // Endpoint and sequencer state.
   logic [6:0] dev_addr_r; // Device address.
   logic [9:0] buf_base_r; // Upper ten bits of the buffer area.
   logic [7:0] tx_ctl_r [0:2]; // Transmit control per endpoint.
   logic [7:0] rx_ctl_r [0:2]; // Receive control per endpoint.
   logic ctr_r; // Correct-transfer flag.
   logic usbrst_flag_r; // Bus reset event flag.
   logic force_reset_r; // Software forced interface reset.
   logic force_q_r; // Previous force value for release edge.
   logic busrst_q_r; // Previous bus reset level.
   logic [1:0] tok_cap_r; // Token PID bits of last correct transfer.
   logic [1:0] ep_cap_r; // Endpoint of last correct transfer.
   logic [3:0] rx_cnt_r; // Bytes received in last correct transfer.
   state_e state_r; // Sequencer state.
   state_e state_nxt; // Next sequencer state.
   logic [1:0] cur_ep_r; // Endpoint of the current transaction.
   logic [1:0] cur_tok_r; // Token of the current transaction.
   logic ack_r; // Bus access answered this cycle.
   logic iface_rst; // Combined interface reset.
   // Hardware update strobes from the sequencer.
   logic ev_ctr; // Correct transfer completes.
   logic hw_tx_nak; // Force transmit status to NAK.
   logic hw_rx_nak; // Force receive status to NAK.
   logic hw_tx_tog_one; // Set transmit toggle.
   logic hw_tx_tog_flip; // Invert transmit toggle.
   logic hw_rx_tog_one; // Receive toggle after SETUP data.
   logic hw_rx_tog_flip; // Invert receive toggle.
   logic [1:0] ev_ep; // Endpoint the strobes address.
   logic hs_valid_nxt; // Handshake pulse next.
   logic [1:0] hs_code_nxt; // Handshake kind next.
   logic tx_start_nxt; // Data send pulse next.
   logic rx_arm_nxt; // Receive arm pulse next.
   logic tok_hit; // Token addresses a known endpoint here.
   logic [1:0] tok_idx; // Endpoint index of the token.
   logic bus_wr; // Write takes effect this edge.
   // Endpoint 0 always answers number 0; 1 and 2 compare the software number.
   function automatic logic [2:0] ep_lookup(input logic [3:0] num,
                                            input logic [3:0] ea1,
                                            input logic [3:0] ea2);
      if (num == 4'h0) begin
         return 3'b100;
      end else if (num == ea1) begin
         return 3'b101;
      end else if (num == ea2) begin
         return 3'b110;
      end
      return 3'b000;
   endfunction
   // Any of the three resets clears the interface.
   assign iface_rst = rst | usb_reset_in | force_reset_r;
   // One wait state per access gives time to register the read data.
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
   assign bus_wr = avs_write & ack_r & avs_byteenable[0];
   // Answer tracking for the Avalon slave.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= (avs_read | avs_write) & ~ack_r;
      end
   end
   // Read data is latched in the wait cycle and stands at the answering edge.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         avs_readdata <= 32'h0000_0000;
      end else if (avs_read & ~ack_r) begin
         avs_readdata <= 32'h0000_0000;
         case (avs_address)
            `OFS_DEVICE_ID: avs_readdata[7:0] <= {1'b0, dev_addr_r};
            `OFS_BUF_BASE: avs_readdata[7:0] <= buf_base_r[9:2];
            `OFS_EP_ID: avs_readdata[7:0] <= {buf_base_r[1:0], ep_cap_r, rx_cnt_r};
            `OFS_TOKEN_CAP: avs_readdata[7:0] <= {tok_cap_r, 6'h00};
            `OFS_STATUS: avs_readdata[7:0] <= {2'b00, ctr_r, 3'b000, usbrst_flag_r, 1'b0};
            `OFS_CONTROL: avs_readdata[`F_FRC_RST] <= force_reset_r;
            `OFS_EP0_TX: avs_readdata[7:0] <= tx_ctl_r[0];
            `OFS_EP0_RX: avs_readdata[7:0] <= {1'b1, rx_ctl_r[0][6:4], 4'h0};
            `OFS_EP1_TX: avs_readdata[7:0] <= tx_ctl_r[1];
            `OFS_EP1_RX: avs_readdata[7:0] <= rx_ctl_r[1];
            `OFS_EP2_TX: avs_readdata[7:0] <= tx_ctl_r[2];
            `OFS_EP2_RX: avs_readdata[7:0] <= rx_ctl_r[2];
            default: avs_readdata <= 32'h0000_0000;
         endcase
      end
   end
   // Force reset control only resets with the system, so software can release it.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         force_reset_r <= 1'b0;
         force_q_r <= 1'b0;
         busrst_q_r <= 1'b0;
      end else begin
         force_q_r <= force_reset_r;
         busrst_q_r <= usb_reset_in;
         if (bus_wr && avs_address == `OFS_CONTROL) begin
            force_reset_r <= avs_writedata[`F_FRC_RST];
         end
      end
   end
   // Status flags: write one to clear; a new event wins; bus reset start or forced release sets.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ctr_r <= 1'b0;
         usbrst_flag_r <= 1'b0;
      end else begin
         if (bus_wr && avs_address == `OFS_STATUS) begin
            if (avs_writedata[`F_CTR]) begin
               ctr_r <= 1'b0;
            end
            if (avs_writedata[`F_USBRST]) begin
               usbrst_flag_r <= 1'b0;
            end
         end
         if (ev_ctr) begin
            ctr_r <= 1'b1;
         end
         if ((usb_reset_in & ~busrst_q_r) | (force_q_r & ~force_reset_r)) begin
            usbrst_flag_r <= 1'b1;
         end
      end
   end
   // Buffer base bits stay over bus resets; only system reset clears them.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         buf_base_r <= `RST_BUF_BASE;
      end else if (bus_wr && avs_address == `OFS_BUF_BASE) begin
         buf_base_r[9:2] <= avs_writedata[7:0];
      end else if (bus_wr && avs_address == `OFS_EP_ID) begin
         buf_base_r[1:0] <= avs_writedata[7:6];
      end
   end
   // Capture of the last correct transfer; frozen while the flag is pending.
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         tok_cap_r <= 2'b00;
         ep_cap_r <= 2'b00;
         rx_cnt_r <= 4'h0;
      end else if (ev_ctr && !ctr_r) begin
         tok_cap_r <= cur_tok_r;
         ep_cap_r <= cur_ep_r;
         rx_cnt_r <= (cur_tok_r == TOK_IN) ? 4'h0 : data_len;
      end
   end
   // Device address: software writes it, any interface reset clears it.
   always_ff @(posedge sys_clk) begin
      if (iface_rst) begin
         dev_addr_r <= `RST_DEVICE_ID;
      end else if (bus_wr && avs_address == `OFS_DEVICE_ID) begin
         dev_addr_r <= avs_writedata[6:0];
      end
   end
   // Endpoint registers; hardware updates follow the write so a race keeps the NAK.
   always_ff @(posedge sys_clk) begin
      if (iface_rst) begin
         for (int i = 0; i < 3; i++) begin
            tx_ctl_r[i] <= `RST_EP_TX;
            rx_ctl_r[i] <= (i == 0) ? `RST_EP0_RX : `RST_EP_RX;
         end
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (bus_wr && avs_address == 4'(`OFS_EP0_TX + 2 * i)) begin
               tx_ctl_r[i] <= avs_writedata[7:0];
            end
            if (bus_wr && avs_address == 4'(`OFS_EP0_RX + 2 * i)) begin
               rx_ctl_r[i] <= avs_writedata[7:0];
            end
            if (ev_ep == 2'(i)) begin
               if (hw_tx_nak) begin
                  tx_ctl_r[i][`F_STAT_HI:`F_STAT_LO] <= STAT_NAK;
               end
               if (hw_rx_nak) begin
                  rx_ctl_r[i][`F_STAT_HI:`F_STAT_LO] <= STAT_NAK;
               end
               if (hw_tx_tog_one) begin
                  tx_ctl_r[i][`F_TOG] <= 1'b1;
               end else if (hw_tx_tog_flip) begin
                  tx_ctl_r[i][`F_TOG] <= ~tx_ctl_r[i][`F_TOG];
               end
               // SETUP data sets the toggle to one directly; accepted OUT data flips it.
               if (hw_rx_tog_one) begin
                  rx_ctl_r[i][`F_TOG] <= 1'b1;
               end else if (hw_rx_tog_flip) begin
                  rx_ctl_r[i][`F_TOG] <= ~rx_ctl_r[i][`F_TOG];
               end
            end
         end
      end
   end
   // Token decode against the endpoint table.
   always_comb begin
      logic [2:0] lk;
      lk = ep_lookup(tok_ep, rx_ctl_r[1][3:0], rx_ctl_r[2][3:0]);
      tok_hit = lk[2] & (tok_addr == dev_addr_r);
      tok_idx = lk[1:0];
   end
   // Transaction sequencer decisions.
   always_comb begin
      logic [1:0] txs;
      logic [1:0] rxs;
      logic [1:0] rs;
      logic is_ctl;
      txs = tx_ctl_r[tok_idx][`F_STAT_HI:`F_STAT_LO];
      rxs = rx_ctl_r[tok_idx][`F_STAT_HI:`F_STAT_LO];
      rs = rx_ctl_r[cur_ep_r][`F_STAT_HI:`F_STAT_LO];
      is_ctl = (tok_idx == 2'd0) | rx_ctl_r[tok_idx][`F_TOP];
      state_nxt = state_r;
      ev_ctr = 1'b0;
      hw_tx_nak = 1'b0;
      hw_rx_nak = 1'b0;
      hw_tx_tog_one = 1'b0;
      hw_tx_tog_flip = 1'b0;
      hw_rx_tog_one = 1'b0;
      hw_rx_tog_flip = 1'b0;
      ev_ep = cur_ep_r;
      hs_valid_nxt = 1'b0;
      hs_code_nxt = HS_ACK;
      tx_start_nxt = 1'b0;
      rx_arm_nxt = 1'b0;
      case (state_r)
         ST_IDLE: begin
            if (tok_valid && tok_hit) begin
               case (tok_pid_bits)
                  TOK_IN: begin
                     if (txs == STAT_STALL) begin
                        hs_valid_nxt = 1'b1;
                        hs_code_nxt = HS_STALL;
                     end else if (txs == STAT_NAK || (txs == STAT_VALID && ctr_r)) begin
                        hs_valid_nxt = 1'b1;
                        hs_code_nxt = HS_NAK;
                     end else if (txs == STAT_VALID) begin
                        tx_start_nxt = 1'b1;
                        state_nxt = ST_WAIT_ACK;
                     end
                  end
                  TOK_OUT: begin
                     if (rxs != STAT_DISABLED) begin
                        rx_arm_nxt = (rxs == STAT_VALID) & ~ctr_r;
                        state_nxt = ST_WAIT_DATA;
                     end
                  end
                  TOK_SETUP: begin
                     // A SETUP during a pending flag is dropped so the capture stays frozen.
                     if (is_ctl && rxs != STAT_DISABLED && !ctr_r) begin
                        rx_arm_nxt = 1'b1;
                        state_nxt = ST_WAIT_DATA;
                     end
                  end
                  default: state_nxt = ST_IDLE;
               endcase
            end
         end
         ST_WAIT_DATA: begin
            if (xfer_abort || (data_done && !data_ok)) begin
               state_nxt = ST_IDLE;
            end else if (data_done) begin
               state_nxt = ST_IDLE;
               if (cur_tok_r == TOK_SETUP) begin
                  if (!data_pid1) begin
                     hs_valid_nxt = 1'b1;
                     hs_code_nxt = HS_ACK;
                     ev_ctr = 1'b1;
                     hw_tx_nak = 1'b1;
                     hw_rx_nak = 1'b1;
                     hw_tx_tog_one = 1'b1;
                     hw_rx_tog_one = 1'b1;
                  end
               end else if (rs == STAT_STALL) begin
                  hs_valid_nxt = 1'b1;
                  hs_code_nxt = HS_STALL;
               end else if (rs == STAT_NAK || ctr_r) begin
                  hs_valid_nxt = 1'b1;
                  hs_code_nxt = HS_NAK;
               end else if (tx_ctl_r[cur_ep_r][`F_TOP] && data_len != 4'h0) begin
                  hs_valid_nxt = 1'b1;
                  hs_code_nxt = HS_STALL;
               end else if (data_pid1 != rx_ctl_r[cur_ep_r][`F_TOG]) begin
                  hs_valid_nxt = 1'b1;
                  hs_code_nxt = HS_ACK;
               end else begin
                  hs_valid_nxt = 1'b1;
                  hs_code_nxt = HS_ACK;
                  ev_ctr = 1'b1;
                  hw_rx_nak = 1'b1;
                  hw_rx_tog_flip = 1'b1;
               end
            end
         end
         ST_WAIT_ACK: begin
            if (host_ack) begin
               state_nxt = ST_IDLE;
               ev_ctr = 1'b1;
               hw_tx_nak = 1'b1;
               hw_tx_tog_flip = 1'b1;
            end else if (xfer_abort) begin
               state_nxt = ST_IDLE;
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
   end
   // Sequencer state and transaction context.
   always_ff @(posedge sys_clk) begin
      if (iface_rst) begin
         state_r <= ST_IDLE;
         cur_ep_r <= 2'd0;
         cur_tok_r <= TOK_OUT;
      end else begin
         state_r <= state_nxt;
         if (state_r == ST_IDLE && tok_valid && tok_hit) begin
            cur_ep_r <= tok_idx;
            cur_tok_r <= tok_pid_bits;
         end
      end
   end
   // Registered link outputs.
   always_ff @(posedge sys_clk) begin
      if (iface_rst) begin
         hs_valid <= 1'b0;
         hs_code <= HS_ACK;
         tx_start <= 1'b0;
         tx_data1 <= 1'b0;
         tx_len <= 4'h0;
         rx_arm <= 1'b0;
         buf_addr <= 16'h0000;
         iface_in_reset <= 1'b1;
      end else begin
         iface_in_reset <= 1'b0;
         hs_valid <= hs_valid_nxt;
         hs_code <= hs_code_nxt;
         tx_start <= tx_start_nxt;
         rx_arm <= rx_arm_nxt;
         if (tx_start_nxt) begin
            tx_data1 <= tx_ctl_r[tok_idx][`F_TOG];
            tx_len <= tx_ctl_r[tok_idx][3:0];
         end
         // Each endpoint owns two 8-byte slots, receive below transmit.
         if (tx_start_nxt | rx_arm_nxt) begin
            buf_addr <= {buf_base_r, tok_idx, tx_start_nxt, 3'b000};
         end
      end
   end
endmodule

/* File: usb_ep_ctrl_pkg.sv */
package usb_ep_ctrl_pkg;
   // Transaction sequencer states.
   typedef enum logic [1:0] {
      ST_IDLE      = 2'b00,
      ST_WAIT_DATA = 2'b01,
      ST_WAIT_ACK  = 2'b10
   } state_e;
   // Handshake the device returns to the host.
   typedef enum logic [1:0] {
      HS_ACK   = 2'b00,
      HS_NAK   = 2'b01,
      HS_STALL = 2'b10
   } hs_code_e;
   // Endpoint status field codes, same for transmit and receive.
   typedef enum logic [1:0] {
      STAT_DISABLED = 2'b00,
      STAT_STALL    = 2'b01,
      STAT_NAK      = 2'b10,
      STAT_VALID    = 2'b11
   } stat_e;
   // Token kinds as the two variable PID bits.
   typedef enum logic [1:0] {
      TOK_OUT   = 2'b00,
      TOK_IN    = 2'b10,
      TOK_SETUP = 2'b11
   } tok_e;
endpackage

/* File: usb_ep_ctrl_props.sv */
`timescale 1ns/1ps
// Bus handshake and link answer checks.
module usb_ep_ctrl_props (
   input wire logic sys_clk, // Clock.
   input wire logic rst, // Reset.
   input wire logic avs_read, // Bus read.
   input wire logic avs_write, // Bus write.
   input wire logic avs_waitrequest, // Bus stall.
   input wire logic usb_reset_in, // Bus reset.
   input wire logic tok_valid, // Token pulse.
   input wire logic data_done, // Data end pulse.
   input wire logic hs_valid, // Handshake pulse.
   input wire logic tx_start, // IN data pulse.
   input wire logic rx_arm, // OUT data pulse.
   input wire logic [15:0] buf_addr, // Buffer address.
   input wire logic iface_in_reset // Interface reset.
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   // A newly raised request.
   sequence s_req_new;
      (avs_read || avs_write) && !$past(avs_read || avs_write);
   endsequence
   chk_wait_first: assert property (s_req_new |-> avs_waitrequest)
      else $error("request taken without its wait state");
   chk_wait_one: assert property (s_req_new ##1 (avs_read || avs_write) |-> !avs_waitrequest)
      else $error("wait state longer than one cycle");
   chk_reset_quiet: assert property (usb_reset_in |=> !(hs_valid || tx_start || rx_arm))
      else $error("answer given during bus reset");
   chk_reset_held: assert property (usb_reset_in |=> iface_in_reset)
      else $error("interface not held in reset");
   chk_tx_cause: assert property (tx_start |-> $past(tok_valid))
      else $error("IN data not one edge after a token");
   chk_rx_cause: assert property (rx_arm |-> $past(tok_valid))
      else $error("receive armed without a token");
   chk_hs_cause: assert property (hs_valid |-> $past(tok_valid || data_done))
      else $error("handshake without token or data");
   chk_hs_single: assert property (hs_valid |=> !hs_valid)
      else $error("handshake longer than one cycle");
   chk_buf_align: assert property ((tx_start || rx_arm) |-> buf_addr[3:0] == {tx_start, 3'h0})
      else $error("buffer address not aligned for direction");
endmodule

bind usb_ep_ctrl usb_ep_ctrl_props u_props (.sys_clk, .rst, .avs_read, .avs_write,
   .avs_waitrequest, .usb_reset_in, .tok_valid, .data_done, .hs_valid, .tx_start, .rx_arm,
   .buf_addr, .iface_in_reset);

/* File: usb_ep_ctrl_regs.svh */
`ifndef USB_EP_CTRL_REGS_SVH
`define USB_EP_CTRL_REGS_SVH

// Register word indices on the Avalon-MM slave; byte address is four times the index.
`define OFS_DEVICE_ID   4'h0
`define OFS_BUF_BASE    4'h1
`define OFS_EP_ID       4'h2
`define OFS_TOKEN_CAP   4'h3
`define OFS_STATUS      4'h4
`define OFS_CONTROL     4'h5
`define OFS_EP0_TX      4'h6
`define OFS_EP0_RX      4'h7
`define OFS_EP1_TX      4'h8
`define OFS_EP1_RX      4'h9
`define OFS_EP2_TX      4'ha
`define OFS_EP2_RX      4'hb

// Field positions inside the endpoint control registers.
`define F_TOP           7
`define F_TOG           6
`define F_STAT_HI       5
`define F_STAT_LO       4
// Status register bits.
`define F_CTR           5
`define F_USBRST        1
// Control register bit.
`define F_FRC_RST       0

// Reset values.
`define RST_DEVICE_ID   7'h00
`define RST_EP_TX       8'h00
`define RST_EP_RX       8'h00
`define RST_EP0_RX      8'h80
`define RST_BUF_BASE    10'h000

`endif

/* File: usb_host_model.sv */
`timescale 1ns/1ps
// Host controller model: sends tokens and data packets and acknowledges IN data.
module usb_host_model (
   input wire logic sys_clk, // Clock.
   input wire logic tx_start, // Device sends IN data.
   output logic tok_valid = 1'b0, // Token pulse.
   output logic [1:0] tok_pid_bits = 2'h0, // Token kind.
   output logic [6:0] tok_addr = 7'h00, // Token address.
   output logic [3:0] tok_ep = 4'h0, // Token endpoint.
   output logic data_done = 1'b0, // Data packet end.
   output logic data_ok = 1'b0, // Packet clean.
   output logic data_pid1 = 1'b0, // Packet was DATA1.
   output logic [3:0] data_len = 4'h0, // Packet length.
   output logic host_ack = 1'b0, // ACK after IN data.
   output logic xfer_abort = 1'b0 // This host never times out.
);
   int ack_dly = 1; // IN data to ACK, cycles.
   int cnt = 0; // Countdown to the ACK.
   // The host only ever answers good IN data with ACK.
   always @(posedge sys_clk) begin
      host_ack <= (cnt == 1);
      cnt <= tx_start ? ack_dly : ((cnt > 0) ? cnt - 1 : 0);
   end
   // Called just after an edge; released address and endpoint lines show the inverse.
   task automatic token(input logic [1:0] p, input logic [6:0] a, input logic [3:0] e);
      tok_valid <= 1'b1;
      tok_pid_bits <= p;
      tok_addr <= a;
      tok_ep <= e;
      @(posedge sys_clk);
      tok_valid <= 1'b0;
      tok_addr <= ~a;
      tok_ep <= ~e;
   endtask
   task automatic data(input logic p1, input logic [3:0] n);
      data_done <= 1'b1;
      data_ok <= 1'b1;
      data_pid1 <= p1;
      data_len <= n;
      @(posedge sys_clk);
      data_done <= 1'b0;
      data_len <= ~n;
   endtask
endmodule
